/* File: apfs_params.svh */
// offsets, field positions, reset values and codes for the analog pin function select block
`ifndef APFS_PARAMS_SVH
`define APFS_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define APFS_OFF_PIN_SELECT   4'h0
`define APFS_OFF_CONTROL      4'h4
`define APFS_OFF_STATUS       4'h8

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define APFS_SEL_WIDTH        8
`define APFS_SEL_MASK         8'h7f
`define APFS_SEL_RESET        8'h00
`define APFS_CH6_BIT          6
`define APFS_CH5_BIT          5
`define APFS_CH4_BIT          4
`define APFS_CTL_CHSEL_LSB    0
`define APFS_CTL_CHSEL_MSB    2
`define APFS_CTL_XIN_BIT      3
`define APFS_CTL_XOUT_BIT     4
`define APFS_CTL_IR_BIT       5
`define APFS_CTL_MASK         8'h3f
`define APFS_CTL_RESET        8'h00

// ----------------------------------------------------------------
// channel select codes
// ----------------------------------------------------------------
`define APFS_CHSEL_CH4        3'h4
`define APFS_CHSEL_CH5        3'h5
`define APFS_CHSEL_CH6        3'h6
`define APFS_CHSEL_NONE       3'h7

`endif

/* File: apfs_pkg.sv */
// types for the analog pin function select block
package apfs_pkg;

   // function driven onto a shared pin
   typedef enum logic [1:0] {
      APFS_FN_DIGITAL = 2'b00,
      APFS_FN_ANALOG  = 2'b01,
      APFS_FN_CRYSTAL = 2'b10,
      APFS_FN_IR      = 2'b11
   } apfs_fn_e;

   // bus write handshake states
   typedef enum logic [1:0] {
      APFS_WR_IDLE = 2'b00,
      APFS_WR_RESP = 2'b01
   } apfs_wr_e;

   typedef logic [7:0] apfs_byte_t;

endpackage

/* File: apfs_top.sv */
// analog pin function select: AXI4-Lite registers and shared pin priority
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "apfs_params.svh"

module apfs_top (
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [3:0]             s_axi_awaddr,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   output logic [1:0]                  s_axi_bresp,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   input  wire logic [3:0]             s_axi_araddr,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic [6:0]                  analog_enable,
   output logic [6:0]                  channel_onehot,
   output apfs_pkg::apfs_fn_e          port5_line5_fn,
   output apfs_pkg::apfs_fn_e          port7_line0_fn,
   output apfs_pkg::apfs_fn_e          port6_line7_fn,
   output logic                        conflict
);
   import apfs_pkg::*;

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   apfs_byte_t  sel_reg;
   apfs_byte_t  ctl_reg;
   apfs_wr_e    wr_state_reg;
   logic        aw_got_reg;
   logic        w_got_reg;
   logic [3:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic        w_lane0_reg;
   logic [2:0]  chsel;
   logic        xin_en;
   logic        xout_en;
   logic        ir_en;

   assign chsel   = ctl_reg[`APFS_CTL_CHSEL_MSB:`APFS_CTL_CHSEL_LSB];
   assign xin_en  = ctl_reg[`APFS_CTL_XIN_BIT];
   assign xout_en = ctl_reg[`APFS_CTL_XOUT_BIT];
   assign ir_en   = ctl_reg[`APFS_CTL_IR_BIT];

   // readback of one register word
   function automatic logic [31:0] reg_read(input logic [3:0] a, input apfs_byte_t s,
                                            input apfs_byte_t c, input logic f);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         `APFS_OFF_PIN_SELECT: d = {24'h00_0000, s & `APFS_SEL_MASK};
         `APFS_OFF_CONTROL:    d = {24'h00_0000, c & `APFS_CTL_MASK};
         `APFS_OFF_STATUS:     d = {31'h0000_0000, f};
         default:              d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   function automatic logic addr_ok(input logic [3:0] a);
      return (a == `APFS_OFF_PIN_SELECT) || (a == `APFS_OFF_CONTROL) ||
             (a == `APFS_OFF_STATUS);
   endfunction

   // ----------------------------------------------------------------
   // write channel: address and data in either order
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_got_reg    <= 1'b0;
         w_got_reg     <= 1'b0;
         aw_addr_reg   <= 4'h0;
         w_data_reg    <= 32'h0000_0000;
         w_lane0_reg   <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         wr_state_reg  <= APFS_WR_IDLE;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         case (wr_state_reg)
            APFS_WR_IDLE: begin
               if (s_axi_awvalid && !aw_got_reg && !s_axi_awready) begin
                  s_axi_awready <= 1'b1;
                  aw_got_reg    <= 1'b1;
                  aw_addr_reg   <= s_axi_awaddr;
               end
               if (s_axi_wvalid && !w_got_reg && !s_axi_wready) begin
                  s_axi_wready <= 1'b1;
                  w_got_reg    <= 1'b1;
                  w_data_reg   <= s_axi_wdata;
                  w_lane0_reg  <= s_axi_wstrb[0];
               end
               if (aw_got_reg && w_got_reg) begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= addr_ok(aw_addr_reg) ? 2'h0 : 2'h2;
                  wr_state_reg <= APFS_WR_RESP;
               end
            end
            APFS_WR_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  aw_got_reg   <= 1'b0;
                  w_got_reg    <= 1'b0;
                  wr_state_reg <= APFS_WR_IDLE;
               end
            end
            default: wr_state_reg <= APFS_WR_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // register update, on the same clock edge that bvalid rises
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sel_reg <= `APFS_SEL_RESET;
         ctl_reg <= `APFS_CTL_RESET;
      end else if (wr_state_reg == APFS_WR_IDLE && aw_got_reg && w_got_reg && w_lane0_reg) begin
         if (aw_addr_reg == `APFS_OFF_PIN_SELECT)
            sel_reg <= w_data_reg[7:0] & `APFS_SEL_MASK;
         if (aw_addr_reg == `APFS_OFF_CONTROL)
            ctl_reg <= w_data_reg[7:0] & `APFS_CTL_MASK;
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid) begin
            if (s_axi_rready)
               s_axi_rvalid <= 1'b0;
         end else if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= reg_read(s_axi_araddr, sel_reg, ctl_reg, conflict);
            s_axi_rresp   <= addr_ok(s_axi_araddr) ? 2'h0 : 2'h2;
         end
      end
   end

   // ----------------------------------------------------------------
   // pin function resolution
   // ----------------------------------------------------------------
   apfs_fn_e p55_next;
   apfs_fn_e p70_next;
   apfs_fn_e p67_next;
   logic     conflict_next;

   always_comb begin
      p55_next = xin_en ? APFS_FN_CRYSTAL :
                 sel_reg[`APFS_CH6_BIT] ? APFS_FN_ANALOG : APFS_FN_DIGITAL;
      p70_next = xout_en ? APFS_FN_CRYSTAL :
                 sel_reg[`APFS_CH5_BIT] ? APFS_FN_ANALOG : APFS_FN_DIGITAL;
      p67_next = sel_reg[`APFS_CH4_BIT] ? APFS_FN_ANALOG :
                 ir_en ? APFS_FN_IR : APFS_FN_DIGITAL;
      conflict_next = (xin_en && (sel_reg[`APFS_CH6_BIT] || chsel == `APFS_CHSEL_CH6)) ||
                      (xout_en && (sel_reg[`APFS_CH5_BIT] || chsel == `APFS_CHSEL_CH5)) ||
                      (ir_en && (sel_reg[`APFS_CH4_BIT] || chsel == `APFS_CHSEL_CH4));
   end

   // registered pin outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         analog_enable  <= 7'h00;
         channel_onehot <= 7'h00;
         port5_line5_fn <= APFS_FN_DIGITAL;
         port7_line0_fn <= APFS_FN_DIGITAL;
         port6_line7_fn <= APFS_FN_DIGITAL;
         conflict       <= 1'b0;
      end else begin
         analog_enable  <= sel_reg[6:0];
         channel_onehot <= (chsel == `APFS_CHSEL_NONE) ? 7'h00 : 7'(7'h01 << chsel);
         port5_line5_fn <= p55_next;
         port7_line0_fn <= p70_next;
         port6_line7_fn <= p67_next;
         conflict       <= conflict_next;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_wr_sel;
      wr_state_reg == APFS_WR_IDLE && aw_got_reg && w_got_reg && w_lane0_reg &&
      aw_addr_reg == `APFS_OFF_PIN_SELECT;
   endsequence

   // ----------------------------------------------------------------
   // bus handshake steps
   // ----------------------------------------------------------------
   // address and data both captured, response not yet raised
   sequence s_wr_both;
      wr_state_reg == APFS_WR_IDLE && aw_got_reg && w_got_reg;
   endsequence

   // response raised and held for the master
   sequence s_wr_resp;
      s_axi_bvalid && wr_state_reg == APFS_WR_RESP;
   endsequence

   // a read is answered together with its address pulse
   sequence s_rd_answer;
      s_axi_arready && s_axi_rvalid;
   endsequence

   AST_SEL_WRITE: assert property (@(posedge clk) disable iff (!nrst)
      s_wr_sel |=> sel_reg == ($past(w_data_reg[7:0]) & `APFS_SEL_MASK))
      else $error("pin select write not stored");
   AST_BIT7_ZERO: assert property (@(posedge clk) disable iff (!nrst)
      s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
      else $error("reserved bit set");
   AST_ENABLE_MAP: assert property (@(posedge clk) disable iff (!nrst)
      ##1 analog_enable == $past(sel_reg[6:0]))
      else $error("analog enable map wrong");
   AST_P55_PRIO: assert property (@(posedge clk) disable iff (!nrst)
      xin_en |=> port5_line5_fn == APFS_FN_CRYSTAL)
      else $error("crystal_in lost priority");
   AST_P70_PRIO: assert property (@(posedge clk) disable iff (!nrst)
      !xout_en && sel_reg[`APFS_CH5_BIT] |=> port7_line0_fn == APFS_FN_ANALOG)
      else $error("channel 5 not analog");
   AST_P67_PRIO: assert property (@(posedge clk) disable iff (!nrst)
      sel_reg[`APFS_CH4_BIT] |=> port6_line7_fn == APFS_FN_ANALOG)
      else $error("channel 4 lost priority");
   AST_P67_DIGITAL: assert property (@(posedge clk) disable iff (!nrst)
      !sel_reg[`APFS_CH4_BIT] && !ir_en |=> port6_line7_fn == APFS_FN_DIGITAL)
      else $error("port6_line7 not digital");
   AST_CHSEL_NONE: assert property (@(posedge clk) disable iff (!nrst)
      chsel == `APFS_CHSEL_NONE |=> channel_onehot == 7'h00)
      else $error("code 111 selected a channel");
   AST_RESET_CLEAR: assert property (@(posedge clk)
      $rose(nrst) |-> sel_reg == `APFS_SEL_RESET)
      else $error("pin select not cleared");

   AST_WR_RESP: assert property (@(posedge clk) disable iff (!nrst)
      s_wr_both |=> s_wr_resp)
      else $error("write response not raised");
   AST_SEL_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      !(wr_state_reg == APFS_WR_IDLE && aw_got_reg && w_got_reg && w_lane0_reg &&
        aw_addr_reg == `APFS_OFF_PIN_SELECT) |=> $stable(sel_reg))
      else $error("pin select changed without a write");
   AST_RD_ANSWER: assert property (@(posedge clk) disable iff (!nrst)
      s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_rd_answer)
      else $error("read not answered");
   AST_P55_ANALOG: assert property (@(posedge clk) disable iff (!nrst)
      !xin_en && sel_reg[`APFS_CH6_BIT] |=> port5_line5_fn == APFS_FN_ANALOG)
      else $error("channel 6 not analog");
   AST_P70_CRYSTAL: assert property (@(posedge clk) disable iff (!nrst)
      xout_en |=> port7_line0_fn == APFS_FN_CRYSTAL)
      else $error("crystal_out lost priority");
   AST_P67_IR: assert property (@(posedge clk) disable iff (!nrst)
      !sel_reg[`APFS_CH4_BIT] && ir_en |=> port6_line7_fn == APFS_FN_IR)
      else $error("infrared output not on port6_line7");
   AST_CHSEL_MAP: assert property (@(posedge clk) disable iff (!nrst)
      chsel != `APFS_CHSEL_NONE |=> $onehot(channel_onehot) && channel_onehot[$past(chsel)])
      else $error("channel code maps to wrong line");
   AST_IR_CONFLICT: assert property (@(posedge clk) disable iff (!nrst)
      ir_en && sel_reg[`APFS_CH4_BIT] |=> conflict)
      else $error("infrared and channel 4 not flagged");

endmodule

/* File: analog_pin_function_select_tb.sv */
// self-checking bench for the analog pin function select block
`timescale 1ns/1ns
`include "apfs_params.svh"

module analog_pin_function_select_tb;
   import apfs_pkg::*;

   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid = 1'b0, rready = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid, cnf;
   logic [3:0]        awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0]       wdata = 32'h0, rdata;
   logic [1:0]        bresp, rresp;
   logic [6:0]        aen, onehot;
   apfs_fn_e          f55, f70, f67;
   logic [33:0]       bq[$], rq[$];
   int                n_fail = 0, n_compared = 0, seed = 61169;
   logic [7:0]        sel, ctl;

   always #20 clk = ~clk;

   apfs_top u_dut (.clk(clk), .nrst(nrst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .analog_enable(aen), .channel_onehot(onehot), .port5_line5_fn(f55),
      .port7_line0_fn(f70), .port6_line7_fn(f67), .conflict(cnf));

   // ------------------------------------------------------------
   // comparison and closing report
   // ------------------------------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ------------------------------------------------------------
   // bus master tasks, expectations queued
   // ------------------------------------------------------------
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] er);
      int  n = 0;
      bit  ad = 0, wd = 0, bd = 0;
      @(posedge clk);
      bq.push_back({32'h0, er});
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (!bd && n < 50) begin
         @(posedge clk);
         n++;
         if (ad && wd && bvalid === 1'b1) begin bd = 1; bready <= 1'b0; end
         if (awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
         if (wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
      end
      if (!bd) begin n_fail++; end_sim(); end
   endtask

   task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, input logic [31:0] ed);
      int  n = 0;
      bit  ad = 0, rd = 0;
      @(posedge clk);
      rq.push_back({er, ed});
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (!rd && n < 50) begin
         @(posedge clk);
         n++;
         if (arready === 1'b1) begin ad = 1; arvalid <= 1'b0; end
         if (rvalid === 1'b1) begin rd = 1; rready <= 1'b0; end
      end
      if (!rd || !ad) begin n_fail++; end_sim(); end
   endtask

   // responses checked against the oldest queued note
   always @(posedge clk) begin
      if (nrst === 1'b1 && bvalid === 1'b1 && bready === 1'b1)
         check({32'h0, bresp}, bq.pop_front());
      if (nrst === 1'b1 && rvalid === 1'b1 && rready === 1'b1)
         check({rresp, rdata}, rq.pop_front());
   end

   // ------------------------------------------------------------
   // pin function expectations
   // ------------------------------------------------------------
   task automatic chk_pins(input logic [7:0] s, input logic [7:0] c);
      apfs_fn_e  e55, e70, e67;
      logic      cf;
      logic [6:0] oh;
      repeat (2) @(posedge clk);
      e55 = c[3] ? APFS_FN_CRYSTAL : (s[6] ? APFS_FN_ANALOG : APFS_FN_DIGITAL);
      e70 = c[4] ? APFS_FN_CRYSTAL : (s[5] ? APFS_FN_ANALOG : APFS_FN_DIGITAL);
      e67 = s[4] ? APFS_FN_ANALOG : (c[5] ? APFS_FN_IR : APFS_FN_DIGITAL);
      cf = (c[3] && (s[6] || c[2:0] == 3'h6)) || (c[4] && (s[5] || c[2:0] == 3'h5))
         || (c[5] && (s[4] || c[2:0] == 3'h4));
      oh = (c[2:0] == 3'h7) ? 7'h00 : (7'h01 << c[2:0]);
      check({27'h0, aen}, {27'h0, s[6:0]});
      check({32'h0, f55}, {32'h0, e55});
      check({32'h0, f70}, {32'h0, e70});
      check({32'h0, f67}, {32'h0, e67});
      check({27'h0, onehot}, {27'h0, oh});
      check({33'h0, cnf}, {33'h0, cf});
      axi_rd(`APFS_OFF_STATUS, 2'b00, {31'h0, cf});
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      axi_rd(`APFS_OFF_PIN_SELECT, 2'b00, 32'h0);
      chk_pins(8'h00, 8'h00);
      // independent bits, bit 7 always written as zero
      for (int i = 0; i < 10; i++) begin
         sel = 8'($random(seed)) & 8'h7f;
         axi_wr(`APFS_OFF_PIN_SELECT, {24'h0, sel}, 4'hf, 2'b00);
         axi_rd(`APFS_OFF_PIN_SELECT, 2'b00, {24'h0, sel & 8'h7f});
         chk_pins(sel & 8'h7f, 8'h00);
      end
      for (int k = 0; k < 8; k++) begin
         ctl = k[7:0];
         axi_wr(`APFS_OFF_CONTROL, {24'h0, ctl}, 4'hf, 2'b00);
         axi_rd(`APFS_OFF_CONTROL, 2'b00, {24'h0, ctl});
         chk_pins(sel & 8'h7f, ctl);
      end
      for (int i = 0; i < 40; i++) begin
         sel = 8'($random(seed)) & 8'h7f;
         ctl = 8'($random(seed));
         axi_wr(`APFS_OFF_PIN_SELECT, {24'h0, sel}, 4'hf, 2'b00);
         axi_wr(`APFS_OFF_CONTROL, {24'h0, ctl}, 4'hf, 2'b00);
         chk_pins(sel & 8'h7f, ctl & 8'h3f);
      end
      // unmapped place and a strobe without lane 0 leave the register alone
      axi_wr(`APFS_OFF_PIN_SELECT, 32'h0000002a, 4'hf, 2'b00);
      axi_wr(4'hc, 32'h00000055, 4'hf, 2'b10);
      axi_rd(4'hc, 2'b10, 32'h0);
      axi_wr(`APFS_OFF_PIN_SELECT, 32'h00000055, 4'he, 2'b00);
      axi_rd(`APFS_OFF_PIN_SELECT, 2'b00, 32'h0000002a);
      axi_wr(`APFS_OFF_PIN_SELECT, 32'h0000007f, 4'hf, 2'b00);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      check({27'h0, aen}, 34'h0);
      nrst <= 1'b1;
      axi_rd(`APFS_OFF_PIN_SELECT, 2'b00, 32'h0);
      chk_pins(8'h00, 8'h00);
      repeat (4) @(posedge clk);
      end_sim();
   end

endmodule
